/* File: verilog/psc_map.svh */
// Purpose: constants of the synthesizer control and status block
// Assumes: byte offsets on a 24-bit address, 16-bit data
// Notes:   definitions only
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH
`define PSC_CTRL_ADDR   24'hc3_0000
`define PSC_STAT_ADDR   24'hc3_0002
`define PSC_CTRL_RST    16'h2100
`define PSC_CTRL_WMASK  16'hffec
`define PSC_ST_MODE     7
`define PSC_ST_SEL      6
`define PSC_ST_REF      5
`define PSC_ST_PLL_LOCKED_STICKY    4
`define PSC_ST_LOCK     3
`define PSC_ST_CLK_LOSS_STICKY     2
`define PSC_STP_ALL     2'h0
`define PSC_STP_NOCLK   2'h1
`define PSC_STP_NOPLL   2'h2
`define PSC_STP_NOOSC   2'h3
`define PSC_MODE_EXT    3'h0
`define PSC_MODE_1TO1   3'h4
`define PSC_MODE_NEXT   3'h6
`define PSC_MODE_NXTAL  3'h7
`define PSC_MFD_OFS     4'h2
`define PSC_ONE_MULT    4'h1
`define PSC_EXT_SHIFT   3'h1
`endif

/* File: verilog/psc_pkg.sv */
// Purpose: types of the synthesizer control and status block
// Assumes: constants live in psc_map.svh
// Notes:   control layout follows the bus word bit by bit
package psc_pkg;
    typedef struct packed {
        logic       lol_reset_en;
        logic [2:0] feedback_multiplier;
        logic       clk_loss_reset_en;
        logic [2:0] ref_freq_divider;
        logic       clk_loss_detect_en;
        logic       sysclk_output_pin_disable;
        logic       fast_wake;
        logic       zero4;
        logic [1:0] stop_gating_sel;
        logic [1:0] zero10;
    } psc_ctrl_t;
    typedef struct packed {
        logic clock_source_sel;
        logic pll_ratio_sel;
        logic pll_reference_sel;
    } psc_mode_t;
    typedef enum logic [2:0] {
        ST_INIT, ST_RUN, ST_STOP, ST_WAKE_LOCK, ST_WAKE_OSC
    } psc_state_t;
endpackage : psc_pkg

/* File: verilog/psc_top.sv */
// Purpose: control and status of a PLL system clock synthesizer
// Assumes: lock detector, oscillator and PLL are analog, outside
// Notes:   status read data are registered, one cycle late
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "psc_map.svh"

// How it works
// - normal-mode system ratio is (multiplier+2) over 2 to the divider power.
// - lock drops on multiplier change or PLL disabled in stop.
// - loss-of-clock reset when reset enable, detect enable, sticky set.
// - external mode ignores detect, reset enable, divider, fast wake.
// - divider change no relock, applied at system clock falling edge.
// - detect enable turns clock-loss detection on and off only.
// - clock-out disable holds pin low, else pin shows system clock.
// - fast wake enables clocks at once, else waits for lock.
// - slow wake after unintended loss uses self-clocked or ref mode.
// - stop disables system clocks; stop field gates PLL, osc, pin.
// - status always readable; writes to it do nothing, no error.
// - mode straps latched at reset encode the four clock modes.
// - sticky lock set on lock after reset or multiplier change.
// - sticky lock frozen over PLL-off stop, hidden after fast wake from it.
// - sticky lock after reset is clear external, set in PLL modes.
// - live lock follows the lock detector thresholds.
// - read coinciding with flag change may show the old value.
// - live lock feeds power-on reset release; clear in external mode.
// - sticky clock loss set by failure when enabled; 0 external.
// - after fast wake from full stop, clock loss reads set till osc.
module psc_top
(
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        RESET_N,
    // register port
    input  wire logic [23:0] ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    // mode straps, caught after reset release
    input  wire logic        STRAP_PLL_EN,
    input  wire logic        STRAP_PLL_SEL,
    input  wire logic        STRAP_PLL_REF,
    // analog status
    input  wire logic        LOCK_DET,
    input  wire logic        REF_FAIL,
    input  wire logic        PLL_FAIL,
    input  wire logic        OSC_READY,
    // power manager
    input  wire logic        STOP_REQ,
    // synthesizer controls
    output logic      [2:0]  FB_MULT,
    output logic      [3:0]  SYS_MULT,
    output logic      [2:0]  SYS_SHIFT,
    output logic             RELOCK,
    output logic             PLL_EN,
    output logic             OSC_EN,
    output logic             SYSCLK_EN,
    output logic             SCM_MODE,
    output logic             REF_MODE,
    output logic             LOCK_OUT,
    output logic             LOC_RESET,
    output logic             SYSCLK_OUTPUT_PIN
);
    psc_pkg::psc_ctrl_t  ctrl_r;
    psc_pkg::psc_ctrl_t  ctrl_nxt;
    psc_pkg::psc_mode_t  mode_r;
    psc_pkg::psc_state_t state_r;
    psc_pkg::psc_state_t state_nxt;
    logic [15:0] rdata_nxt;
    logic [7:0]  status;
    logic [2:0]  rfd_eff_r;
    logic [3:0]  mult_nxt;
    logic [2:0]  shift_nxt;
    logic        phase_r;
    logic        lock_r;
    logic        lock_nxt;
    logic        pll_locked_sticky_r;
    logic        pll_locked_sticky_nxt;
    logic        arm_r;
    logic        hide_r;
    logic        clk_loss_sticky_r;
    logic        lost_osc_r;
    logic        lost_pll_r;
    logic        scm_nxt;
    logic        refm_nxt;

    function automatic logic hit(input logic [23:0] a,
                                 input logic [23:0] b);
        hit = (a == b);
    endfunction : hit

    // decode
    wire logic ctrl_sel  = hit(ADDR, `PSC_CTRL_ADDR);
    wire logic stat_sel  = hit(ADDR, `PSC_STAT_ADDR);
    wire logic ctrl_wr   = WR && ctrl_sel;
    wire logic pll_mode  = mode_r.clock_source_sel;
    wire logic norm_mode = pll_mode && mode_r.pll_ratio_sel;
    wire logic in_stop   = (state_r == psc_pkg::ST_STOP);
    wire logic wake_osc  = (state_r == psc_pkg::ST_WAKE_OSC);
    wire logic [1:0] stp = ctrl_r.stop_gating_sel;

    // writes to status fall through untouched and need no error
    assign ctrl_nxt = ctrl_wr ? psc_pkg::psc_ctrl_t'(WDATA
                      & `PSC_CTRL_WMASK) : ctrl_r;

    wire logic mfd_chg = ctrl_wr && (WDATA[14:12]
                         != ctrl_r.feedback_multiplier);
    wire logic pll_off = in_stop && stp[1];
    wire logic osc_off = in_stop && (stp == `PSC_STP_NOOSC);
    wire logic pin_off = in_stop && (stp != `PSC_STP_ALL);
    wire logic fw_eff  = ctrl_r.fast_wake && pll_mode;
    wire logic det_en  = pll_mode && ctrl_r.clk_loss_detect_en;
    wire logic fail    = REF_FAIL || PLL_FAIL;
    wire logic wake    = in_stop && !STOP_REQ;
    wire logic lost    = lost_osc_r || lost_pll_r;

    // stop and wakeup sequencing
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            // a stop already pending at release goes straight to stop
            psc_pkg::ST_INIT:
                if (STOP_REQ)
                    state_nxt = psc_pkg::ST_STOP;
                else
                    state_nxt = psc_pkg::ST_RUN;
            psc_pkg::ST_RUN:
                if (STOP_REQ)
                    state_nxt = psc_pkg::ST_STOP;
            psc_pkg::ST_STOP:
                if (!STOP_REQ)
                begin
                    if (!pll_mode)
                        state_nxt = psc_pkg::ST_RUN;
                    else if (fw_eff && stp == `PSC_STP_NOOSC)
                        state_nxt = psc_pkg::ST_WAKE_OSC;
                    else if (fw_eff || lost)
                        state_nxt = psc_pkg::ST_RUN;
                    else
                        state_nxt = psc_pkg::ST_WAKE_LOCK;
                end
            // a new stop during a wake wins, so clocks never run in stop
            psc_pkg::ST_WAKE_LOCK:
                if (STOP_REQ)
                    state_nxt = psc_pkg::ST_STOP;
                else if (LOCK_DET)
                    state_nxt = psc_pkg::ST_RUN;
            psc_pkg::ST_WAKE_OSC:
                if (STOP_REQ)
                    state_nxt = psc_pkg::ST_STOP;
                else if (OSC_READY)
                    state_nxt = psc_pkg::ST_RUN;
            default:
                state_nxt = psc_pkg::ST_INIT;
        endcase
    end

    // wake modes for a fast wake from full stop, or after a loss in a slow-wake stop
    assign scm_nxt  = (state_nxt == psc_pkg::ST_WAKE_OSC)
                      || (wake && !fw_eff && lost_osc_r)
                      || (SCM_MODE && !STOP_REQ
                          && !(wake_osc && OSC_READY));
    assign refm_nxt = (wake && !fw_eff && !lost_osc_r && lost_pll_r)
                      || (REF_MODE && !STOP_REQ);

    // live lock; forced low across a multiplier change or PLL-off stop
    assign lock_nxt = pll_mode && LOCK_DET && !mfd_chg
                      && !pll_off;
    wire logic lock_rise = lock_nxt && !lock_r;
    wire logic lock_fall = lock_r && !lock_nxt;

    // sticky lock: set wins over the clearing loss in one cycle
    always_comb
    begin
        pll_locked_sticky_nxt = pll_locked_sticky_r;
        if (state_r == psc_pkg::ST_INIT)
            pll_locked_sticky_nxt = STRAP_PLL_EN;
        else if (pll_off)
            pll_locked_sticky_nxt = pll_locked_sticky_r;
        else if (lock_rise && arm_r)
            pll_locked_sticky_nxt = 1'b1;
        else if (lock_fall && !hide_r)
            pll_locked_sticky_nxt = 1'b0;
    end

    // ratio handed to the synthesizer
    assign mult_nxt  = norm_mode ? ({1'b0, ctrl_r.feedback_multiplier}
                       + `PSC_MFD_OFS) : `PSC_ONE_MULT;
    assign shift_nxt = !pll_mode ? `PSC_EXT_SHIFT
                       : (norm_mode ? rfd_eff_r : 3'h0);

    // status image; unassigned bits stay zero
    always_comb
    begin
        status = 8'h00;
        status[`PSC_ST_MODE]  = mode_r.clock_source_sel;
        status[`PSC_ST_SEL]   = mode_r.pll_ratio_sel;
        status[`PSC_ST_REF]   = mode_r.pll_reference_sel;
        status[`PSC_ST_PLL_LOCKED_STICKY] = pll_locked_sticky_r && !hide_r;
        status[`PSC_ST_LOCK]  = lock_r;
        status[`PSC_ST_CLK_LOSS_STICKY]  = pll_mode && (clk_loss_sticky_r || wake_osc);
    end

    // read data come from the flags as they stood at the strobe
    always_comb
    begin
        rdata_nxt = 16'h0000;
        if (RD && ctrl_sel)
            rdata_nxt = ctrl_r;
        else if (RD && stat_sel)
            rdata_nxt = {8'h00, status};
    end

    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            state_r <= psc_pkg::ST_INIT;
            ctrl_r  <= psc_pkg::psc_ctrl_t'(`PSC_CTRL_RST);
            RDATA   <= 16'h0000;
        end
        else
        begin
            state_r <= state_nxt;
            ctrl_r  <= ctrl_nxt;
            RDATA   <= rdata_nxt;
        end
    end

    // straps are caught once, in the first cycle after release
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
            mode_r <= '0;
        else if (state_r == psc_pkg::ST_INIT)
            mode_r <= {STRAP_PLL_EN, STRAP_PLL_EN && STRAP_PLL_SEL,
                       STRAP_PLL_EN && STRAP_PLL_SEL
                       && STRAP_PLL_REF};
    end

    // lock flags
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            lock_r  <= 1'b0;
            pll_locked_sticky_r <= 1'b0;
            arm_r   <= 1'b0;
            hide_r  <= 1'b0;
        end
        else
        begin
            lock_r  <= lock_nxt;
            pll_locked_sticky_r <= pll_locked_sticky_nxt;
            arm_r   <= (state_r == psc_pkg::ST_INIT) || mfd_chg
                       || (arm_r && !lock_rise);
            hide_r  <= (wake && fw_eff && stp[1])
                       || (hide_r && !lock_rise);
        end
    end

    // clock loss: sticky flag until reset, never in external mode; stop-loss flags clear out of stop
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            clk_loss_sticky_r     <= 1'b0;
            lost_osc_r <= 1'b0;
            lost_pll_r <= 1'b0;
        end
        else
        begin
            clk_loss_sticky_r     <= clk_loss_sticky_r || ((det_en || wake_osc)
                          && pll_mode && fail);
            lost_osc_r <= in_stop && (lost_osc_r
                          || (!osc_off && REF_FAIL));
            lost_pll_r <= in_stop && (lost_pll_r
                          || (!pll_off && PLL_FAIL));
        end
    end

    // system clock model and divider hand-over
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            phase_r   <= 1'b0;
            rfd_eff_r <= 3'h1;
        end
        else
        begin
            phase_r <= !phase_r;
            if (phase_r)
                rfd_eff_r <= ctrl_r.ref_freq_divider;
        end
    end

    // outputs, all registered; ratio first
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            FB_MULT   <= 3'h0;
            SYS_MULT  <= 4'h0;
            SYS_SHIFT <= 3'h0;
            RELOCK    <= 1'b0;
        end
        else
        begin
            FB_MULT   <= ctrl_r.feedback_multiplier;
            SYS_MULT  <= mult_nxt;
            SYS_SHIFT <= shift_nxt;
            // divider writes never pulse this, so no relock
            RELOCK    <= mfd_chg && pll_mode;
        end
    end

    // stop gating of PLL, oscillator, system clocks and pin
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            PLL_EN    <= 1'b0;
            OSC_EN    <= 1'b0;
            SYSCLK_EN <= 1'b0;
            SYSCLK_OUTPUT_PIN    <= 1'b0;
        end
        else
        begin
            PLL_EN    <= pll_mode && !pll_off;
            OSC_EN    <= !osc_off;
            SYSCLK_EN <= (state_nxt == psc_pkg::ST_RUN)
                         || (state_nxt == psc_pkg::ST_WAKE_OSC);
            // pin follows the modelled clock, held low when disabled
            SYSCLK_OUTPUT_PIN    <= !phase_r && !ctrl_r.sysclk_output_pin_disable
                         && !pin_off;
        end
    end

    // wake modes of the PLL
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            SCM_MODE  <= 1'b0;
            REF_MODE  <= 1'b0;
        end
        else
        begin
            SCM_MODE  <= scm_nxt;
            REF_MODE  <= refm_nxt;
        end
    end

    // live lock and clock-loss reset request
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            LOCK_OUT  <= 1'b0;
            LOC_RESET <= 1'b0;
        end
        else
        begin
            LOCK_OUT  <= lock_nxt;
            LOC_RESET <= det_en && ctrl_r.clk_loss_reset_en
                         && clk_loss_sticky_r;
        end
    end
endmodule : psc_top

/* File: dv/psc_checker.sv */
// Purpose: port-level assertions for the synthesizer control block
// Assumes: control word rebuilt from bus writes, straps held in run
// Notes:   one clock domain, default clocking and disable
`timescale 1ns/10ps
`include "psc_map.svh"
module psc_checker
(
    // clock and reset
    input wire logic        MCLK,
    input wire logic        RESET_N,
    // register port
    input wire logic [23:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [15:0] RDATA,
    // straps, analog and stop request
    input wire logic        STRAP_PLL_EN,
    input wire logic        STRAP_PLL_SEL,
    input wire logic        STRAP_PLL_REF,
    input wire logic        LOCK_DET,
    input wire logic        STOP_REQ,
    // synthesizer outputs
    input wire logic [2:0]  FB_MULT,
    input wire logic [3:0]  SYS_MULT,
    input wire logic [2:0]  SYS_SHIFT,
    input wire logic        RELOCK,
    input wire logic        SYSCLK_EN,
    input wire logic        LOCK_OUT,
    input wire logic        LOC_RESET,
    input wire logic        SYSCLK_OUTPUT_PIN
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    logic [15:0] ctrl_r;
    wire         ctrl_hit = ADDR == `PSC_CTRL_ADDR;
    wire         stat_hit = ADDR == `PSC_STAT_ADDR;
    wire         normal   = STRAP_PLL_EN && STRAP_PLL_SEL;
    // shadow of the control word, masked like the design
    always_ff @(posedge MCLK or negedge RESET_N)
        if (!RESET_N)
            ctrl_r <= `PSC_CTRL_RST;
        else if (WR && ctrl_hit)
            ctrl_r <= WDATA & `PSC_CTRL_WMASK;
    sequence s_ctrl_rd;
        RD && ctrl_hit;
    endsequence
    sequence s_stat_rd;
        RD && stat_hit;
    endsequence
    chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 16'h0000)
        else $error("read data not zero outside a read");
    chk_ctrl_read: assert property (s_ctrl_rd |=> RDATA == $past(ctrl_r))
        else $error("control readback wrong");
    chk_stat_read: assert property (s_stat_rd |=> RDATA[15:8] == 8'h00
        && RDATA[1:0] == 2'h0
        && RDATA[7:5] == {STRAP_PLL_EN, STRAP_PLL_SEL, STRAP_PLL_REF})
        else $error("status layout wrong");
    chk_relock_once: assert property (RELOCK |->
        $past(WR && ctrl_hit && WDATA[14:12] != ctrl_r[14:12])
        ##1 (!RELOCK || $past(WR && ctrl_hit)))
        else $error("relock pulse wrong");
    chk_sysclk_output_pin_off: assert property (ctrl_r[6] && $past(ctrl_r[6]) |-> !SYSCLK_OUTPUT_PIN)
        else $error("clock out not held low");
    chk_stop_gate: assert property ($past(STOP_REQ) && STOP_REQ |-> !SYSCLK_EN)
        else $error("system clocks on in stop");
    chk_live_lock: assert property (LOCK_OUT |-> $past(LOCK_DET) && STRAP_PLL_EN)
        else $error("live lock without cause");
    chk_loss_reset: assert property (LOC_RESET |->
        $past(ctrl_r[11] && ctrl_r[7]) && STRAP_PLL_EN)
        else $error("clock loss reset without enables");
    chk_mult_norm: assert property (normal && $stable(FB_MULT)
        && $past(RESET_N, 3) && $past(FB_MULT, 2) == FB_MULT
        |-> SYS_MULT == {1'b0, FB_MULT} + 4'h2)
        else $error("normal ratio wrong");
    chk_ext_ratio: assert property (!STRAP_PLL_EN && $past(RESET_N, 3)
        |-> SYS_MULT == 4'h1 && SYS_SHIFT == 3'h1)
        else $error("external ratio wrong");
endmodule : psc_checker

bind psc_top psc_checker i_chk (.MCLK(MCLK), .RESET_N(RESET_N), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .STRAP_PLL_EN(STRAP_PLL_EN), .STRAP_PLL_SEL(STRAP_PLL_SEL),
    .STRAP_PLL_REF(STRAP_PLL_REF), .LOCK_DET(LOCK_DET), .STOP_REQ(STOP_REQ),
    .FB_MULT(FB_MULT), .SYS_MULT(SYS_MULT), .SYS_SHIFT(SYS_SHIFT),
    .RELOCK(RELOCK), .SYSCLK_EN(SYSCLK_EN), .LOCK_OUT(LOCK_OUT),
    .LOC_RESET(LOC_RESET), .SYSCLK_OUTPUT_PIN(SYSCLK_OUTPUT_PIN));

/* File: dv/pll_synth_ctrl_status_bench.sv */
// Purpose: self-checking bench of the synthesizer control block
// Assumes: straps only change while reset is held
// Notes:   loss tested on the reference, pll failure during a stop
`timescale 1ns/10ps
`include "psc_map.svh"
module pll_synth_ctrl_status_bench;
    logic        mclk, reset_n, wr, rd, saw_hi;
    logic [23:0] addr;
    logic [15:0] wdata, rdata;
    logic [2:0]  strap, fb_mult, sys_shift;
    logic [3:0]  sys_mult;
    logic        lock_det, ref_fail, osc_ready, stop_req, relock, pll_en;
    logic        osc_en, sysclk_en, scm_mode, lock_out, loc_reset, sysclk_output_pin;
    logic        pll_fail, ref_mode;
    logic [2:0]  modes [4] = '{3'b000, 3'b100, 3'b110, 3'b111};
    int          fails, samples_checked;
    psc_top i_dut (.MCLK(mclk), .RESET_N(reset_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .STRAP_PLL_EN(strap[2]), .STRAP_PLL_SEL(strap[1]),
        .STRAP_PLL_REF(strap[0]), .LOCK_DET(lock_det), .REF_FAIL(ref_fail),
        .PLL_FAIL(pll_fail), .OSC_READY(osc_ready), .STOP_REQ(stop_req),
        .FB_MULT(fb_mult), .SYS_MULT(sys_mult), .SYS_SHIFT(sys_shift),
        .RELOCK(relock), .PLL_EN(pll_en), .OSC_EN(osc_en),
        .SYSCLK_EN(sysclk_en), .SCM_MODE(scm_mode), .REF_MODE(ref_mode),
        .LOCK_OUT(lock_out), .LOC_RESET(loc_reset), .SYSCLK_OUTPUT_PIN(sysclk_output_pin));
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    function automatic logic [15:0] stat(input logic [2:0] m, f);
        return {8'h00, m, f, 2'b00};
    endfunction : stat
    task automatic chk(input string nm, input logic [15:0] exp, got);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr_reg(input logic [23:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [23:0] a, input logic [15:0] e,
                          input string nm);
        @(posedge mclk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd   <= 1'b0;
        #1;
        chk(nm, e, rdata);
    endtask : rd_reg
    // settle a few edges, then look off the edge
    task automatic wait4;
        repeat (4) @(posedge mclk);
        #1;
    endtask : wait4
    task automatic watch_clk;
        saw_hi = 1'b0;
        repeat (8)
        begin
            @(posedge mclk);
            #1;
            saw_hi = saw_hi | sysclk_output_pin;
        end
    endtask : watch_clk
    task automatic do_reset(input logic [2:0] m);
        @(posedge mclk);
        reset_n <= 1'b0;
        strap   <= m;
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask : do_reset
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    initial
    begin
        #(20000 * 8);
        fails++;
        give_verdict;
    end
    initial
    begin
        {reset_n, wr, rd, addr, wdata, lock_det, ref_fail, stop_req} = '0;
        pll_fail  = 1'b0;
        strap     = 3'b110;
        osc_ready = 1'b1;
        do_reset(3'b110);
        rd_reg(`PSC_CTRL_ADDR, `PSC_CTRL_RST, "ctrl reset");
        wr_reg(`PSC_STAT_ADDR, 16'hffff);
        rd_reg(`PSC_STAT_ADDR, stat(3'b110, 3'b100), "status write");
        wr_reg(24'hc3_0004, 16'hffff);
        rd_reg(24'hc3_0004, 16'h0000, "unmapped");
        wr_reg(`PSC_CTRL_ADDR, 16'h3313);
        #1;
        chk("relock", 16'h0001, 16'(relock));
        rd_reg(`PSC_CTRL_ADDR, 16'h3300, "ctrl mask");
        wait4;
        chk("mult", 16'h0005, 16'(sys_mult));
        chk("fb mult", 16'h0003, 16'(fb_mult));
        chk("shift", 16'h0003, 16'(sys_shift));
        // lock after a multiplier change, then loss and plain relock
        @(posedge mclk);
        lock_det <= 1'b1;
        rd_reg(`PSC_STAT_ADDR, stat(3'b110, 3'b110), "locked");
        @(posedge mclk);
        lock_det <= 1'b0;
        rd_reg(`PSC_STAT_ADDR, stat(3'b110, 3'b000), "lost");
        @(posedge mclk);
        lock_det <= 1'b1;
        rd_reg(`PSC_STAT_ADDR, stat(3'b110, 3'b010), "relocked");
        chk("lock out", 16'h0001, 16'(lock_out));
        wr_reg(`PSC_CTRL_ADDR, 16'h3340);
        watch_clk;
        chk("sysclk_output_pin off", 16'h0000, 16'(saw_hi));
        wr_reg(`PSC_CTRL_ADDR, 16'h3300);
        watch_clk;
        chk("sysclk_output_pin on", 16'h0001, 16'(saw_hi));
        for (int c = 0; c < 4; c++)
        begin
            wr_reg(`PSC_CTRL_ADDR, {12'h330, 2'(c), 2'b00});
            @(posedge mclk);
            lock_det <= 1'b0;
            stop_req <= 1'b1;
            wait4;
            chk("sysclk stop", 16'h0000, 16'(sysclk_en));
            chk("pll stop", 16'(c < 2), 16'(pll_en));
            chk("osc stop", 16'(c < 3), 16'(osc_en));
            watch_clk;
            chk("sysclk_output_pin stop", 16'(c == 0), 16'(saw_hi));
            @(posedge mclk);
            stop_req <= 1'b0;
            wait4;
            chk("slow wake", 16'h0000, 16'(sysclk_en));
            @(posedge mclk);
            lock_det <= 1'b1;
            wait4;
            chk("wake locked", 16'h0001, 16'(sysclk_en));
        end
        // pll lost in a slow-wake stop: wake on the reference clock
        wr_reg(`PSC_CTRL_ADDR, 16'h3300);
        @(posedge mclk);
        {pll_fail, stop_req} <= 2'b11;
        wait4;
        @(posedge mclk);
        {pll_fail, stop_req} <= 2'b00;
        wait4;
        chk("ref mode", 16'h0001, 16'(ref_mode));
        chk("scm off", 16'h0000, 16'(scm_mode));
        chk("lost wake", 16'h0001, 16'(sysclk_en));
        // fast wake from full stop, oscillator still starting
        wr_reg(`PSC_CTRL_ADDR, 16'h332c);
        @(posedge mclk);
        {osc_ready, lock_det, stop_req} <= 3'b001;
        wait4;
        @(posedge mclk);
        stop_req <= 1'b0;
        wait4;
        chk("fast wake", 16'h0001, 16'(sysclk_en));
        chk("self clocked", 16'h0001, 16'(scm_mode));
        rd_reg(`PSC_STAT_ADDR, stat(3'b110, 3'b001), "osc start");
        @(posedge mclk);
        osc_ready <= 1'b1;
        rd_reg(`PSC_STAT_ADDR, stat(3'b110, 3'b000), "osc up");
        // clock loss with detection off, then on
        wr_reg(`PSC_CTRL_ADDR, 16'h3b00);
        @(posedge mclk);
        {lock_det, ref_fail} <= 2'b11;
        rd_reg(`PSC_STAT_ADDR, stat(3'b110, 3'b010), "loss off");
        chk("loss reset off", 16'h0000, 16'(loc_reset));
        wr_reg(`PSC_CTRL_ADDR, 16'h3b80);
        wait4;
        chk("loss reset", 16'h0001, 16'(loc_reset));
        rd_reg(`PSC_STAT_ADDR, stat(3'b110, 3'b011), "loss on");
        @(posedge mclk);
        ref_fail <= 1'b0;
        wr_reg(`PSC_CTRL_ADDR, 16'h3b00);
        wait4;
        chk("loss reset gate", 16'h0000, 16'(loc_reset));
        rd_reg(`PSC_STAT_ADDR, stat(3'b110, 3'b011), "loss sticky");
        for (int m = 0; m < 4; m++)
        begin
            do_reset(modes[m]);
            rd_reg(`PSC_STAT_ADDR, stat(modes[m],
                   {modes[m][2], modes[m][2], 1'b0}), "mode status");
            chk("mode mult", 16'(modes[m][1] ? 4'h4 : 4'h1),
                16'(sys_mult));
            chk("mode shift", 16'(modes[m] != 3'b100), 16'(sys_shift));
        end
        give_verdict;
    end
endmodule : pll_synth_ctrl_status_bench
